// ==== core/dprs_pkg.sv ====
// Package: constants and carriers of the display power and reset sequencer
package dprs_pkg;

   // ======================================================================
   // Register offsets
   localparam logic [3:0] DPRS_OFS_CTRL     = 4'h0;
   localparam logic [3:0] DPRS_OFS_CONTRAST = 4'h1;
   localparam logic [3:0] DPRS_OFS_START    = 4'h2;
   localparam logic [3:0] DPRS_OFS_COLUMN   = 4'h3;
   localparam logic [3:0] DPRS_OFS_STATUS   = 4'h4;
   localparam logic [3:0] DPRS_OFS_SHIFT    = 4'h5;
   localparam logic [3:0] DPRS_OFS_PUMP     = 4'h6;

   // ======================================================================
   // Control field positions
   localparam int DPRS_BIT_DISP_ON   = 0;
   localparam int DPRS_BIT_SEG_REMAP = 1;
   localparam int DPRS_BIT_COM_REV   = 2;
   localparam int DPRS_BIT_ENTIRE_ON = 3;
   localparam int DPRS_BIT_INVERSE   = 4;
   localparam int DPRS_BIT_MODE_ALT  = 5;

   // ======================================================================
   // Reset values
   localparam logic [7:0] DPRS_RST_CONTRAST = 8'h7F;
   localparam logic [5:0] DPRS_RST_START    = 6'h00;
   localparam logic [6:0] DPRS_RST_COLUMN   = 7'h00;
   localparam logic [7:0] DPRS_RST_SHIFT    = 8'h00;
   localparam logic [7:0] DPRS_RST_PUMP     = 8'h10;
   localparam logic [7:0] DPRS_PUMP_ON_VAL  = 8'h14;

   // ======================================================================
   // Timing: high-voltage settle wait
   localparam int  DPRS_SETTLE_MS     = 100;
   localparam int  DPRS_CLK_MHZ       = 100;
   localparam int  DPRS_SETTLE_CYCLES = DPRS_SETTLE_MS * 1000 * DPRS_CLK_MHZ;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic       disp_on;
      logic       seg_remap;
      logic       com_rev;
      logic       entire_on;
      logic       inverse;
      logic       mode_alt;
   } dprs_ctrl_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dprs_bus_type;

endpackage

// ==== core/dprs_shift_in.sv ====
// Serial host interface shift register, cleared on reset
`timescale 1ns/1ns
module dprs_shift_in
   import dprs_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             bit_valid,
   input  wire logic             bit_value,
   output logic [WIDTH-1:0]      shift_ff,
   output logic [3:0]            count_ff,
   output logic                  byte_done_ff
);

   // Four-bit count and byte strobe only serve an eight-bit word
   if (WIDTH != 8)
   begin : g_bad_width
      $error("dprs_shift_in: WIDTH must be 8");
   end

   logic [WIDTH-1:0] nxt_shift;
   logic [3:0]       nxt_count;
   logic             nxt_byte_done;

   always_comb
   begin
      nxt_shift     = shift_ff;
      nxt_count     = count_ff;
      nxt_byte_done = 1'b0;
      if (bit_valid)
      begin
         nxt_shift = {shift_ff[WIDTH-2:0], bit_value};
         if (count_ff == 4'(WIDTH - 1))
         begin
            nxt_count     = 4'h0;
            nxt_byte_done = 1'b1;
         end
         else
         begin
            nxt_count = count_ff + 4'h1;
         end
      end
   end

   // Partial bits are discarded under reset
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_ff     <= DPRS_RST_SHIFT;
         count_ff     <= 4'h0;
         byte_done_ff <= 1'b0;
      end
      else
      begin
         shift_ff     <= nxt_shift;
         count_ff     <= nxt_count;
         byte_done_ff <= nxt_byte_done;
      end
   end

endmodule // dprs_shift_in

// ==== core/dprs_settle_timer.sv ====
// Settle timer: flags when the high-voltage wait has elapsed
`timescale 1ns/1ns
module dprs_settle_timer
   import dprs_pkg::*;
#(
   parameter int CYCLES = DPRS_SETTLE_CYCLES
)
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic run,
   output logic      done_ff
);

   // Zero would wrap the end-of-count compare and never flag ready
   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("dprs_settle_timer: CYCLES must be positive");
   end

   logic [31:0] count_ff;
   logic [31:0] nxt_count;
   logic        nxt_done;

   always_comb
   begin
      nxt_count = 32'h0;
      nxt_done  = 1'b0;
      if (run)
      begin
         if (count_ff >= 32'(CYCLES - 1))
         begin
            nxt_count = count_ff;
            nxt_done  = 1'b1;
         end
         else
         begin
            nxt_count = count_ff + 32'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_ff <= 32'h0;
         done_ff  <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         done_ff  <= nxt_done;
      end
   end

endmodule // dprs_settle_timer

// ==== core/dprs_core.sv ====
// Top: display controller reset state, register port and supply status
// ==========================================================================
// Behaviour
// - Reset low forces display off and 128x64 mode.
// - Reset restores normal segment and common mapping and scan direction.
// - Reset clears serial shift register, discarding partial bits.
// - Reset sets start line to 0 and column counter to 0.
// - Reset loads contrast with 7Fh.
// - Reset enters normal display, pixels follow memory contents.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module dprs_core
   import dprs_pkg::*;
#(
   parameter int SETTLE_CYCLES = DPRS_SETTLE_CYCLES
)
(
   input  wire logic       clock,
   input  wire logic       chip_reset_low,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       ser_bit_valid,
   input  wire logic       ser_bit_value,
   input  wire logic       hv_supply_on,
   output logic [7:0]      rdata_ff,
   output logic            panel_lit_ff,
   output logic            first_segment_driver_col0_ff,
   output logic            first_common_driver_row0_ff,
   output logic [7:0]      contrast_out_ff,
   output logic            pixel_follow_mem_ff,
   output logic            hv_ready_ff
);

   // ======================================================================
   // Local state
   logic          rst_b;
   dprs_ctrl_type ctrl_ff;
   dprs_ctrl_type nxt_ctrl;
   logic [7:0]    contrast_ff;
   logic [7:0]    nxt_contrast;
   logic [5:0]    start_ff;
   logic [5:0]    nxt_start;
   logic [6:0]    column_ff;
   logic [6:0]    nxt_column;
   logic [7:0]    pump_ff;
   logic [7:0]    nxt_pump;
   logic [7:0]    nxt_rdata;
   logic [7:0]    shift_q;
   logic [3:0]    shift_cnt;
   logic          byte_done;
   logic          settle_done;
   dprs_bus_type  bus;

   assign rst_b = chip_reset_low;
   assign bus   = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Zero would leave the settle flag unreachable
   if (SETTLE_CYCLES < 1)
   begin : g_bad_settle
      $error("dprs_core: SETTLE_CYCLES must be positive");
   end

   function automatic logic [7:0] status_word(input logic p_lit, input logic p_hv,
                                              input logic p_ready, input logic p_pump);
      status_word = {4'h0, p_pump, p_ready, p_hv, p_lit};
   endfunction

   // ======================================================================
   // Serial shift register and high-voltage settle timer
   dprs_shift_in #(.WIDTH(8)) u_shift (
      .clock        (clock),
      .rst_b        (rst_b),
      .bit_valid    (ser_bit_valid),
      .bit_value    (ser_bit_value),
      .shift_ff     (shift_q),
      .count_ff     (shift_cnt),
      .byte_done_ff (byte_done)
   );

   // Host's 100 ms wait is observed, not enforced: panel may be lit earlier
   dprs_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
      .clock   (clock),
      .rst_b   (rst_b),
      .run     (hv_supply_on),
      .done_ff (settle_done)
   );

   // ======================================================================
   // Register writes
   always_comb
   begin
      nxt_ctrl     = ctrl_ff;
      nxt_contrast = contrast_ff;
      nxt_start    = start_ff;
      nxt_column   = column_ff;
      nxt_pump     = pump_ff;
      // Each received data byte advances the column counter up to 7Fh
      if (byte_done && column_ff != 7'h7F)
      begin
         nxt_column = column_ff + 7'h01;
      end
      // Only a column write outranks the advance; other writes must not lose it
      if (bus.wr)
      begin
         if (bus.addr == DPRS_OFS_CTRL)
         begin
            nxt_ctrl.disp_on   = bus.wdata[DPRS_BIT_DISP_ON];
            nxt_ctrl.seg_remap = bus.wdata[DPRS_BIT_SEG_REMAP];
            nxt_ctrl.com_rev   = bus.wdata[DPRS_BIT_COM_REV];
            nxt_ctrl.entire_on = bus.wdata[DPRS_BIT_ENTIRE_ON];
            nxt_ctrl.inverse   = bus.wdata[DPRS_BIT_INVERSE];
            nxt_ctrl.mode_alt  = bus.wdata[DPRS_BIT_MODE_ALT];
         end
         else if (bus.addr == DPRS_OFS_CONTRAST)
         begin
            nxt_contrast = bus.wdata;
         end
         else if (bus.addr == DPRS_OFS_START)
         begin
            nxt_start = bus.wdata[5:0];
         end
         else if (bus.addr == DPRS_OFS_COLUMN)
         begin
            nxt_column = bus.wdata[6:0];
         end
         else if (bus.addr == DPRS_OFS_PUMP)
         begin
            nxt_pump = bus.wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_ff     <= '0;                 // Off, 128x64, normal map
         contrast_ff <= DPRS_RST_CONTRAST;
         start_ff    <= DPRS_RST_START;
         column_ff   <= DPRS_RST_COLUMN;
         pump_ff     <= DPRS_RST_PUMP;
      end
      else
      begin
         ctrl_ff     <= nxt_ctrl;
         contrast_ff <= nxt_contrast;
         start_ff    <= nxt_start;
         column_ff   <= nxt_column;
         pump_ff     <= nxt_pump;
      end
   end

   // ======================================================================
   // Register reads; unmapped offsets answer zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      if (bus.rd)
      begin
         if (bus.addr == DPRS_OFS_CTRL)
         begin
            nxt_rdata = {2'b00, ctrl_ff.mode_alt, ctrl_ff.inverse, ctrl_ff.entire_on,
                         ctrl_ff.com_rev, ctrl_ff.seg_remap, ctrl_ff.disp_on};
         end
         else if (bus.addr == DPRS_OFS_CONTRAST)
         begin
            nxt_rdata = contrast_ff;
         end
         else if (bus.addr == DPRS_OFS_START)
         begin
            nxt_rdata = {2'b00, start_ff};
         end
         else if (bus.addr == DPRS_OFS_COLUMN)
         begin
            nxt_rdata = {1'b0, column_ff};
         end
         else if (bus.addr == DPRS_OFS_STATUS)
         begin
            nxt_rdata = status_word(ctrl_ff.disp_on, hv_supply_on, settle_done,
                                    pump_ff == DPRS_PUMP_ON_VAL);
         end
         else if (bus.addr == DPRS_OFS_SHIFT)
         begin
            nxt_rdata = shift_q;
         end
         else if (bus.addr == DPRS_OFS_PUMP)
         begin
            nxt_rdata = pump_ff;
         end
      end
   end

   // ======================================================================
   // Registered outputs
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_ff                     <= 8'h00;
         panel_lit_ff                 <= 1'b0;
         first_segment_driver_col0_ff <= 1'b1;
         first_common_driver_row0_ff  <= 1'b1;
         contrast_out_ff              <= DPRS_RST_CONTRAST;
         pixel_follow_mem_ff          <= 1'b1;
         hv_ready_ff                  <= 1'b0;
      end
      else
      begin
         rdata_ff                     <= nxt_rdata;
         panel_lit_ff                 <= nxt_ctrl.disp_on;
         first_segment_driver_col0_ff <= ~nxt_ctrl.seg_remap;
         first_common_driver_row0_ff  <= ~nxt_ctrl.com_rev;
         contrast_out_ff              <= nxt_contrast;
         pixel_follow_mem_ff          <= ~nxt_ctrl.entire_on;
         hv_ready_ff                  <= settle_done;
      end
   end

   // ======================================================================
   // Checks
   // Low only up to the first edge after release, where reset values must still stand
   logic rel_ff;
   logic nxt_rel;

   always_comb
   begin
      nxt_rel = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rel_ff <= 1'b0;
      end
      else
      begin
         rel_ff <= nxt_rel;
      end
   end

   sequence s_first_edge;
      !rel_ff;
   endsequence

   sequence s_ctrl_write;
      wr && addr == DPRS_OFS_CTRL;
   endsequence

   // A column write in the same cycle takes the counter instead
   sequence s_byte_advance;
      byte_done && column_ff != 7'h7F && !(wr && addr == DPRS_OFS_COLUMN);
   endsequence

   a_reset_panel_off: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> !panel_lit_ff && !ctrl_ff.mode_alt)
      else $error("panel lit after reset");

   a_reset_mapping: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> first_segment_driver_col0_ff && first_common_driver_row0_ff)
      else $error("mapping not normal after reset");

   a_shift_cleared: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> shift_cnt == 4'h0 && shift_q == DPRS_RST_SHIFT)
      else $error("shift register not cleared");

   a_start_zero: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> start_ff == DPRS_RST_START && column_ff == DPRS_RST_COLUMN)
      else $error("start/column not zero");

   a_contrast_init: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> contrast_out_ff == DPRS_RST_CONTRAST)
      else $error("contrast not at reset value");

   a_normal_display: assert property (@(posedge clock) disable iff (!rst_b)
      s_first_edge |-> pixel_follow_mem_ff)
      else $error("display not normal");

   a_lit_follows_ctrl: assert property (@(posedge clock) disable iff (!rst_b)
      s_ctrl_write |=> panel_lit_ff == $past(wdata[DPRS_BIT_DISP_ON]))
      else $error("lit output does not follow control write");

   a_mapping_write: assert property (@(posedge clock) disable iff (!rst_b)
      s_ctrl_write |=> first_segment_driver_col0_ff == !$past(wdata[DPRS_BIT_SEG_REMAP])
                       && first_common_driver_row0_ff == !$past(wdata[DPRS_BIT_COM_REV]))
      else $error("mapping does not follow control write");

   a_pixel_write: assert property (@(posedge clock) disable iff (!rst_b)
      s_ctrl_write |=> pixel_follow_mem_ff == !$past(wdata[DPRS_BIT_ENTIRE_ON]))
      else $error("display mode does not follow control write");

   a_contrast_write: assert property (@(posedge clock) disable iff (!rst_b)
      wr && addr == DPRS_OFS_CONTRAST |=> contrast_out_ff == $past(wdata))
      else $error("contrast output does not follow write");

   a_column_advance: assert property (@(posedge clock) disable iff (!rst_b)
      s_byte_advance |=> column_ff == $past(column_ff) + 7'h01)
      else $error("column counter did not advance");

   a_hv_drop: assert property (@(posedge clock) disable iff (!rst_b)
      !hv_supply_on |-> ##2 !hv_ready_ff)
      else $error("ready stands without supply");

   a_read_latency: assert property (@(posedge clock) disable iff (!rst_b)
      rd && addr == DPRS_OFS_CONTRAST && !wr |=> rdata_ff == $past(contrast_ff))
      else $error("contrast read wrong");

endmodule // dprs_core

// ==== testbench/dprs_host_model.sv ====
// Host-side model: high-voltage supply control and serial bit stream
`timescale 1ns/1ns
module dprs_host_model
#(
   parameter int SETTLE = 20
)
(
   input  wire logic clock,
   output logic      ser_bit_valid,
   output logic      ser_bit_value,
   output logic      hv_supply_on
);
   // ======================================================================
   // Idle levels
   initial
   begin
      ser_bit_valid = 1'b0;
      ser_bit_value = 1'b1;
      hv_supply_on  = 1'b0;
   end

   // ======================================================================
   // Serial bits, MSB first; n below 8 leaves a partial byte on purpose
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--)
      begin
         @(posedge clock);
         ser_bit_valid <= 1'b1;
         ser_bit_value <= b[i];
      end
      @(posedge clock);
      ser_bit_valid <= 1'b0;
      // Released line shows the inverse, never a stale copy
      ser_bit_value <= ~b[8-n];
   endtask

   // ======================================================================
   // High-voltage supply; only switched after display-off and setup
   task automatic hv_set(input logic on);
      @(posedge clock);
      hv_supply_on <= on;
      // Discharge wait before the logic supply may go
      if (!on)
         repeat (SETTLE) @(posedge clock);
   endtask
endmodule // dprs_host_model

// ==== testbench/tb_dprs_core.sv ====
// Testbench for the display power and reset sequencer
`timescale 1ns/1ns
module tb_dprs_core
   import dprs_pkg::*;
;
   // ======================================================================
   // Signals
   localparam int SETTLE = 20;
   logic       clock          = 1'b0;
   logic       chip_reset_low = 1'b0;
   logic [3:0] addr           = 4'h0;
   logic [7:0] wdata          = 8'h00;
   logic       wr             = 1'b0;
   logic       rd             = 1'b0;
   logic       ser_bit_valid;
   logic       ser_bit_value;
   logic       hv_supply_on;
   logic [7:0] rdata_ff;
   logic [7:0] contrast_out_ff;
   logic       panel_lit_ff;
   logic       seg_ok;
   logic       com_ok;
   logic       pix_ok;
   logic       hv_ready_ff;
   logic [7:0] out_vec;
   int         n_fail      = 0;
   int         check_count = 0;

   always #5 clock = ~clock;
   assign out_vec = {3'h0, panel_lit_ff, seg_ok, com_ok, pix_ok, hv_ready_ff};

   dprs_core #(.SETTLE_CYCLES(SETTLE)) dut_u
   (
      .clock                        (clock),
      .chip_reset_low               (chip_reset_low),
      .addr                         (addr),
      .wdata                        (wdata),
      .wr                           (wr),
      .rd                           (rd),
      .ser_bit_valid                (ser_bit_valid),
      .ser_bit_value                (ser_bit_value),
      .hv_supply_on                 (hv_supply_on),
      .rdata_ff                     (rdata_ff),
      .panel_lit_ff                 (panel_lit_ff),
      .first_segment_driver_col0_ff (seg_ok),
      .first_common_driver_row0_ff  (com_ok),
      .contrast_out_ff              (contrast_out_ff),
      .pixel_follow_mem_ff          (pix_ok),
      .hv_ready_ff                  (hv_ready_ff)
   );

   dprs_host_model #(.SETTLE(SETTLE)) host_u
   (
      .clock         (clock),
      .ser_bit_valid (ser_bit_valid),
      .ser_bit_value (ser_bit_value),
      .hv_supply_on  (hv_supply_on)
   );

   // ======================================================================
   // Tasks
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(rdata_ff, e);
   endtask

   task automatic pulse_reset();
      @(posedge clock);
      chip_reset_low <= 1'b0;
      #2;
      chk(out_vec, 8'h0E);
      chk(contrast_out_ff, DPRS_RST_CONTRAST);
      repeat (2) @(posedge clock);
      chip_reset_low <= 1'b1;
   endtask

   task automatic check_reset_regs();
      reg_rd(DPRS_OFS_CTRL, 8'h00);
      reg_rd(DPRS_OFS_CONTRAST, 8'h7F);
      reg_rd(DPRS_OFS_START, 8'h00);
      reg_rd(DPRS_OFS_COLUMN, 8'h00);
      reg_rd(DPRS_OFS_SHIFT, 8'h00);
   endtask

   // Bounded wait; ready must not come early nor much late
   task automatic wait_ready();
      int n;
      n = 0;
      repeat (SETTLE - 2) @(posedge clock);
      #1;
      chk({7'h00, hv_ready_ff}, 8'h00);
      while (hv_ready_ff !== 1'b1 && n < 8)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({7'h00, hv_ready_ff}, 8'h01);
   endtask

   task automatic complete_run();
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ======================================================================
   // Watchdog: whole run is well under a thousand cycles
   initial
   begin
      #200000;
      n_fail++;
      complete_run();
   end

   // ======================================================================
   // Tests
   initial
   begin
      repeat (20) @(posedge clock);
      #1;
      chk(out_vec, 8'h0E);
      chk(contrast_out_ff, 8'h7F);
      chk(rdata_ff, 8'h00);
      @(posedge clock);
      chip_reset_low <= 1'b1;
      check_reset_regs();
      reg_rd(DPRS_OFS_PUMP, DPRS_RST_PUMP);
      reg_rd(4'hF, 8'h00);
      // Disturb every reset target except pump and settle timer, then reset with three bits of a byte sent
      reg_wr(DPRS_OFS_CTRL, 8'h3F);
      chk(out_vec, 8'h10);
      reg_wr(DPRS_OFS_CONTRAST, 8'h55);
      chk(contrast_out_ff, 8'h55);
      reg_wr(DPRS_OFS_START, 8'h2A);
      reg_wr(DPRS_OFS_COLUMN, 8'h33);
      // Writes must land, or the reset reads below prove nothing
      reg_rd(DPRS_OFS_CTRL, 8'h3F);
      reg_rd(DPRS_OFS_START, 8'h2A);
      reg_rd(DPRS_OFS_COLUMN, 8'h33);
      host_u.send_bits(8'hC0, 3);
      pulse_reset();
      check_reset_regs();
      // Stale partial bits would misalign this byte
      host_u.send_bits(8'hA5, 8);
      repeat (3) @(posedge clock);
      reg_rd(DPRS_OFS_SHIFT, 8'hA5);
      reg_rd(DPRS_OFS_COLUMN, 8'h01);
      // A stale bit count would complete a byte here and move the column
      host_u.send_bits(8'h3C, 5);
      repeat (3) @(posedge clock);
      reg_rd(DPRS_OFS_COLUMN, 8'h01);
      // Power-up, cut short by a reset before display-on
      reg_wr(DPRS_OFS_CTRL, 8'h00);
      reg_wr(DPRS_OFS_PUMP, DPRS_PUMP_ON_VAL);
      host_u.hv_set(1'b1);
      wait_ready();
      pulse_reset();
      host_u.hv_set(1'b0);
      reg_rd(DPRS_OFS_PUMP, DPRS_RST_PUMP);
      // Full restart from the first step
      reg_wr(DPRS_OFS_CTRL, 8'h00);
      reg_wr(DPRS_OFS_PUMP, DPRS_PUMP_ON_VAL);
      host_u.hv_set(1'b1);
      wait_ready();
      reg_rd(DPRS_OFS_STATUS, 8'h0E);
      reg_wr(DPRS_OFS_CTRL, 8'h01);
      chk(out_vec, 8'h1F);
      reg_rd(DPRS_OFS_STATUS, 8'h0F);
      // Power-down
      reg_wr(DPRS_OFS_CTRL, 8'h00);
      chk(out_vec, 8'h0F);
      host_u.hv_set(1'b0);
      chk(out_vec, 8'h0E);
      reg_rd(DPRS_OFS_STATUS, 8'h08);
      complete_run();
   end
endmodule // tb_dprs_core
